// ---- rtl/shunt_rebuild_pkg.sv ----
// Purpose: shared constants for single shunt phase current rebuilding
// Assumes: 12-bit unsigned current-sense ADC codes
// Notes: phase indices select the winding that a bus sample represents
package shunt_rebuild_pkg;
  localparam int ADC_W = 12;
  localparam int CUR_W = ADC_W + 1;
  localparam int OUT_W = ADC_W + 2;
  localparam logic [ADC_W-1:0] NOMINAL_ZERO_CODE = 12'h800;
  localparam logic [ADC_W-1:0] DEFAULT_DEVIATION = 12'h096;
  localparam int DEFAULT_CHECK_SAMPLES = 64;
  localparam int NUM_PHASES = 3;
  localparam int NUM_GATES = 6;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] PHASE_A = 2'h0;
  localparam logic [1:0] PHASE_B = 2'h1;
  localparam logic [1:0] PHASE_C = 2'h2;
  // switch state codes, leg a in the top bit
  localparam logic [2:0] SW_ZERO_LOW = 3'h0;
  localparam logic [2:0] SW_ZERO_HIGH = 3'h7;
  localparam logic [2:0] SW_A_ONLY = 3'h4;
  localparam logic [2:0] SW_B_ONLY = 3'h2;
  localparam logic [2:0] SW_C_ONLY = 3'h1;
  localparam logic [2:0] SW_B_C = 3'h3;
  localparam logic [2:0] SW_A_C = 3'h5;
  localparam logic [2:0] SW_A_B = 3'h6;
endpackage

// ---- rtl/single_shunt_phase_current_rebuild.sv ----
// Purpose: rebuilds three winding currents from single shunt bus samples
// Assumes: gate pins are asynchronous; adc strobe and period pulse share core_clk
// Notes: offset calibration runs first on idle samples, then reconstruction
module single_shunt_phase_current_rebuild #(
  parameter int OFFSET_CHECK_SAMPLE_COUNT = shunt_rebuild_pkg::DEFAULT_CHECK_SAMPLES,
  parameter logic [shunt_rebuild_pkg::ADC_W-1:0] OFFSET_ALLOWED_DEVIATION =
    shunt_rebuild_pkg::DEFAULT_DEVIATION
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic leg_a_high_gate,
  input wire logic leg_a_low_gate,
  input wire logic leg_b_high_gate,
  input wire logic leg_b_low_gate,
  input wire logic leg_c_high_gate,
  input wire logic leg_c_low_gate,
  input wire logic period_start,
  input wire logic motor_idle,
  input wire logic shunt_sample_valid,
  input wire logic [shunt_rebuild_pkg::ADC_W-1:0] shunt_bus_current,
  output logic signed [shunt_rebuild_pkg::OUT_W-1:0] phase_a_current,
  output logic signed [shunt_rebuild_pkg::OUT_W-1:0] phase_b_current,
  output logic signed [shunt_rebuild_pkg::OUT_W-1:0] phase_c_current,
  output logic phase_currents_valid,
  output logic [shunt_rebuild_pkg::ADC_W-1:0] applied_offset,
  output logic offset_ok,
  output logic offset_fault,
  output logic gate_fault
);
  localparam int ADC_W = shunt_rebuild_pkg::ADC_W;
  localparam int CUR_W = shunt_rebuild_pkg::CUR_W;
  localparam int OUT_W = shunt_rebuild_pkg::OUT_W;
  localparam int NP = shunt_rebuild_pkg::NUM_PHASES;
  localparam int NG = shunt_rebuild_pkg::NUM_GATES;
  localparam int CNT_LOG = $clog2(OFFSET_CHECK_SAMPLE_COUNT);
  localparam int ACC_W = ADC_W + CNT_LOG;
  localparam logic [CNT_LOG-1:0] LAST_COUNT = CNT_LOG'(OFFSET_CHECK_SAMPLE_COUNT - 1);
  // per leg high gate off and low gate on, matching the pins of an idle inverter
  localparam logic [NG-1:0] GATE_IDLE = {NP{2'h1}};

  // averaging is a shift, so the count must be a power of two of at least two
  if (OFFSET_CHECK_SAMPLE_COUNT < 2 ||
      (1 << CNT_LOG) != OFFSET_CHECK_SAMPLE_COUNT)
  begin : bad_count
    $error("offset check sample count must be a power of two, at least 2");
  end

  typedef enum logic [1:0] {CALIBRATE, RUN, FAULT} mode_e;

  // gate pins cross into core_clk through two flops
  logic [NG-1:0] gate_pins;
  logic [NG-1:0] gate_meta_q;
  logic [NG-1:0] gate_sync_q;
  assign gate_pins = {leg_a_high_gate, leg_a_low_gate, leg_b_high_gate,
    leg_b_low_gate, leg_c_high_gate, leg_c_low_gate};

  for (genvar g = 0; g < NG; g++)
  begin : gate_sync
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        // idle levels keep the complement check quiet right after reset
        gate_meta_q[g] <= GATE_IDLE[g];
        gate_sync_q[g] <= GATE_IDLE[g];
      end
      else
      begin
        gate_meta_q[g] <= gate_pins[g];
        gate_sync_q[g] <= gate_meta_q[g];
      end
    end
  end

  switch_state_if sw ();

  switch_state_decoder decoder_i (
    .leg_a_high_gate(gate_sync_q[5]),
    .leg_a_low_gate(gate_sync_q[4]),
    .leg_b_high_gate(gate_sync_q[3]),
    .leg_b_low_gate(gate_sync_q[2]),
    .leg_c_high_gate(gate_sync_q[1]),
    .leg_c_low_gate(gate_sync_q[0]),
    .sw(sw.decoder)
  );

  // mode, calibration and reconstruction state
  mode_e mode_q, mode_d;
  logic [ACC_W-1:0] acc_q, acc_d;
  logic [CNT_LOG-1:0] count_q, count_d;
  logic [ADC_W-1:0] offset_q, offset_d;
  logic fault_q, fault_d;
  logic gate_fault_q, gate_fault_d;
  logic [NP-1:0] seen_q, seen_d;
  logic done_q, done_d;
  logic signed [CUR_W-1:0] cur_q [NP];
  logic signed [CUR_W-1:0] cur_d [NP];
  logic signed [OUT_W-1:0] out_q [NP];
  logic signed [OUT_W-1:0] out_d [NP];
  logic valid_q, valid_d;

  logic [ACC_W-1:0] acc_sum;
  logic [ADC_W-1:0] average;
  logic [ADC_W-1:0] deviation;
  logic signed [CUR_W-1:0] centred;
  logic signed [CUR_W-1:0] signed_sample;
  logic use_sample;

  assign acc_sum = acc_q + ACC_W'(shunt_bus_current);
  assign average = acc_sum[ACC_W-1:CNT_LOG];
  assign deviation = (average >= shunt_rebuild_pkg::NOMINAL_ZERO_CODE) ?
    average - shunt_rebuild_pkg::NOMINAL_ZERO_CODE :
    shunt_rebuild_pkg::NOMINAL_ZERO_CODE - average;
  // subtract the applied zero-current offset
  assign centred = $signed({1'b0, shunt_bus_current}) - $signed({1'b0, offset_q});
  assign signed_sample = sw.negate ? -centred : centred;
  // zero vectors carry no phase information
  assign use_sample = shunt_sample_valid && (mode_q == RUN) && !sw.zero_vector
    && sw.gates_consistent && !seen_q[sw.phase] && !done_q;

  always_comb
  begin
    mode_d = mode_q;
    acc_d = acc_q;
    count_d = count_q;
    offset_d = offset_q;
    fault_d = fault_q;
    gate_fault_d = gate_fault_q | (|sw.code & ~sw.gates_consistent) |
      (~sw.gates_consistent & ~|sw.code);
    case (mode_q)
      CALIBRATE:
      begin
        // average idle samples
        if (shunt_sample_valid && motor_idle)
        begin
          acc_d = acc_sum;
          count_d = count_q + 1'b1;
          if (count_q == LAST_COUNT)
          begin
            acc_d = '0;
            count_d = '0;
            // accept only within the allowed deviation
            if (deviation <= OFFSET_ALLOWED_DEVIATION)
            begin
              offset_d = average;
              mode_d = RUN;
            end
            else
            begin
              fault_d = 1'b1;
              mode_d = FAULT;
            end
          end
        end
      end
      RUN:
        mode_d = RUN;
      FAULT:
        mode_d = FAULT; // sticky until reset
      default:
        mode_d = CALIBRATE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= CALIBRATE;
      acc_q <= '0;
      count_q <= '0;
      offset_q <= shunt_rebuild_pkg::NOMINAL_ZERO_CODE;
      fault_q <= 1'b0;
      gate_fault_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      acc_q <= acc_d;
      count_q <= count_d;
      offset_q <= offset_d;
      fault_q <= fault_d;
      gate_fault_q <= gate_fault_d;
    end
  end

  // per-period capture of two distinct phases and rebuild of the third
  always_comb
  begin
    seen_d = seen_q;
    done_d = done_q;
    valid_d = 1'b0;
    for (int i = 0; i < NP; i++)
    begin
      cur_d[i] = cur_q[i];
      out_d[i] = out_q[i];
    end
    if (period_start)
    begin
      // a new period forgets the previous captures
      seen_d = '0;
      done_d = 1'b0;
    end
    else if (use_sample)
    begin
      // a repeated phase is ignored so the pair is distinct
      cur_d[sw.phase] = signed_sample;
      seen_d[sw.phase] = 1'b1;
      if (seen_q != '0)
      begin
        done_d = 1'b1;
        valid_d = 1'b1;
        for (int i = 0; i < NP; i++)
        begin
          if (seen_d[i])
            out_d[i] = OUT_W'(cur_d[i]);
          else
            // negated sum of the other two
            out_d[i] = -(OUT_W'(cur_d[(i + 1) % NP]) + OUT_W'(cur_d[(i + 2) % NP]));
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      seen_q <= '0;
      done_q <= 1'b0;
      valid_q <= 1'b0;
      for (int i = 0; i < NP; i++)
      begin
        cur_q[i] <= '0;
        out_q[i] <= '0;
      end
    end
    else
    begin
      seen_q <= seen_d;
      done_q <= done_d;
      valid_q <= valid_d;
      for (int i = 0; i < NP; i++)
      begin
        cur_q[i] <= cur_d[i];
        out_q[i] <= out_d[i];
      end
    end
  end

  assign phase_a_current = out_q[shunt_rebuild_pkg::PHASE_A];
  assign phase_b_current = out_q[shunt_rebuild_pkg::PHASE_B];
  assign phase_c_current = out_q[shunt_rebuild_pkg::PHASE_C];
  assign phase_currents_valid = valid_q;
  assign applied_offset = offset_q;
  assign offset_ok = (mode_q == RUN);
  assign offset_fault = fault_q;
  assign gate_fault = gate_fault_q;
endmodule

// ---- rtl/switch_state_decoder.sv ----
// Purpose: maps the six gate levels to a switch state and current meaning
// Assumes: gate levels already synchronised to core_clk
// Notes: purely combinational
module switch_state_decoder (
  input wire logic leg_a_high_gate,
  input wire logic leg_a_low_gate,
  input wire logic leg_b_high_gate,
  input wire logic leg_b_low_gate,
  input wire logic leg_c_high_gate,
  input wire logic leg_c_low_gate,
  switch_state_if.decoder sw
);
  logic [2:0] state_code;

  // leg state is the high gate; low gate must be its complement
  assign state_code = {leg_a_high_gate, leg_b_high_gate, leg_c_high_gate};
  assign sw.code = state_code;
  assign sw.gates_consistent = (leg_a_high_gate ^ leg_a_low_gate)
    & (leg_b_high_gate ^ leg_b_low_gate) & (leg_c_high_gate ^ leg_c_low_gate);

  always_comb
  begin
    sw.zero_vector = 1'b0;
    sw.phase = shunt_rebuild_pkg::PHASE_A;
    sw.negate = 1'b0;
    case (state_code)
      shunt_rebuild_pkg::SW_ZERO_LOW, shunt_rebuild_pkg::SW_ZERO_HIGH:
        sw.zero_vector = 1'b1;
      shunt_rebuild_pkg::SW_A_ONLY:
        sw.phase = shunt_rebuild_pkg::PHASE_A;
      shunt_rebuild_pkg::SW_B_ONLY:
        sw.phase = shunt_rebuild_pkg::PHASE_B;
      shunt_rebuild_pkg::SW_C_ONLY:
        sw.phase = shunt_rebuild_pkg::PHASE_C;
      shunt_rebuild_pkg::SW_B_C:
      begin
        sw.phase = shunt_rebuild_pkg::PHASE_A;
        sw.negate = 1'b1;
      end
      shunt_rebuild_pkg::SW_A_C:
      begin
        sw.phase = shunt_rebuild_pkg::PHASE_B;
        sw.negate = 1'b1;
      end
      shunt_rebuild_pkg::SW_A_B:
      begin
        sw.phase = shunt_rebuild_pkg::PHASE_C;
        sw.negate = 1'b1;
      end
      default:
        sw.zero_vector = 1'b1;
    endcase
  end
endmodule

// ---- rtl/switch_state_if.sv ----
// Purpose: carries the decoded inverter switch state
// Assumes: decoder drives, rebuild logic reads
// Notes: all fields combinational from synchronised gates
interface switch_state_if;
  logic [2:0] code;
  logic zero_vector;
  logic [1:0] phase;
  logic negate;
  logic gates_consistent;
  modport decoder (output code, output zero_vector, output phase, output negate,
    output gates_consistent);
  modport user (input code, input zero_vector, input phase, input negate,
    input gates_consistent);
endinterface

// ---- test/shunt_drive_model.sv ----
// Purpose: behavioural inverter gate driver and bus-current adc
// Assumes: driven by the bench through the send task
// Notes: bus code is inverted once its sample pulse has passed
module shunt_drive_model (
  input wire logic core_clk,
  output logic leg_a_high_gate,
  output logic leg_a_low_gate,
  output logic leg_b_high_gate,
  output logic leg_b_low_gate,
  output logic leg_c_high_gate,
  output logic leg_c_low_gate,
  output logic shunt_sample_valid,
  output logic [11:0] shunt_bus_current
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] sw_q = 3'h0;
  initial
  begin
    shunt_sample_valid = 1'b0;
    shunt_bus_current = 12'h000;
  end
  assign {leg_a_high_gate, leg_b_high_gate, leg_c_high_gate} = sw_q;
  assign {leg_a_low_gate, leg_b_low_gate, leg_c_low_gate} = ~sw_q;
  task automatic send(input logic [2:0] sw, input logic [11:0] code, input int settle);
    @(negedge core_clk);
    sw_q = sw;
    repeat (settle) @(negedge core_clk);
    shunt_bus_current = code;
    shunt_sample_valid = 1'b1;
    @(negedge core_clk);
    shunt_sample_valid = 1'b0;
    shunt_bus_current = ~code;
  endtask
endmodule

// ---- test/shunt_rebuild_assertions.sv ----
// Purpose: port-level checks of the single shunt current rebuild block
// Assumes: one clock domain, async active-high reset
// Notes: attached to the top module by bind
module shunt_rebuild_checker #(
  parameter int OFFSET_CHECK_SAMPLE_COUNT = 64,
  parameter logic [11:0] OFFSET_ALLOWED_DEVIATION = 12'h096
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic leg_a_high_gate,
  input wire logic leg_a_low_gate,
  input wire logic leg_b_high_gate,
  input wire logic leg_b_low_gate,
  input wire logic leg_c_high_gate,
  input wire logic leg_c_low_gate,
  input wire logic period_start,
  input wire logic motor_idle,
  input wire logic shunt_sample_valid,
  input wire logic [11:0] shunt_bus_current,
  input wire logic signed [13:0] phase_a_current,
  input wire logic signed [13:0] phase_b_current,
  input wire logic signed [13:0] phase_c_current,
  input wire logic phase_currents_valid,
  input wire logic [11:0] applied_offset,
  input wire logic offset_ok,
  input wire logic offset_fault,
  input wire logic gate_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  int cal_cnt_q;
  int cal_cnt_d;
  logic [2:0] high_gates;
  logic signed [15:0] cur_sum;
  assign high_gates = {leg_a_high_gate, leg_b_high_gate, leg_c_high_gate};
  assign cur_sum = phase_a_current + phase_b_current + phase_c_current;
  // counts idle samples offered while calibration is still open
  always_comb
  begin
    cal_cnt_d = cal_cnt_q;
    if (shunt_sample_valid && motor_idle && !offset_ok && !offset_fault)
      cal_cnt_d = cal_cnt_q + 1;
  end
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      cal_cnt_q <= 0;
    else
      cal_cnt_q <= cal_cnt_d;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  fault_sticky_a: assert property (offset_fault |=> offset_fault)
    else $error("offset fault dropped");
  fault_blocks_a: assert property (offset_fault |-> !phase_currents_valid)
    else $error("currents valid despite offset fault");
  offset_window_a: assert property (offset_ok |->
    applied_offset >= 12'h800 - OFFSET_ALLOWED_DEVIATION &&
    applied_offset <= 12'h800 + OFFSET_ALLOWED_DEVIATION) else $error("offset outside window");
  offset_hold_a: assert property (offset_ok |=> offset_ok && $stable(applied_offset))
    else $error("applied offset changed after acceptance");
  zero_vector_skip_a: assert property (phase_currents_valid |->
    !($past(high_gates, 3) inside {3'h0, 3'h7})) else $error("rebuild from zero vector");
  valid_after_sample_a: assert property (phase_currents_valid |-> $past(shunt_sample_valid))
    else $error("currents valid without a sample");
  phase_sum_a: assert property (phase_currents_valid |-> cur_sum == 16'sh0)
    else $error("three currents do not sum to zero");
  cal_count_a: assert property ($rose(offset_ok) || $rose(offset_fault) |->
    cal_cnt_q == OFFSET_CHECK_SAMPLE_COUNT) else $error("calibration ended at wrong count");
  cal_done_a: assert property (shunt_sample_valid && motor_idle && !offset_ok &&
    !offset_fault && cal_cnt_q == OFFSET_CHECK_SAMPLE_COUNT - 1 |=> offset_ok != offset_fault)
    else $error("calibration verdict missing");
  cover property ($rose(offset_ok));
  cover property ($rose(offset_fault));
  cover property (phase_currents_valid);
endmodule

bind single_shunt_phase_current_rebuild shunt_rebuild_checker #(
  .OFFSET_CHECK_SAMPLE_COUNT(OFFSET_CHECK_SAMPLE_COUNT),
  .OFFSET_ALLOWED_DEVIATION(OFFSET_ALLOWED_DEVIATION)
) u_checker (.*);

// ---- test/single_shunt_phase_current_rebuild_bench.sv ----
// Purpose: self-checking bench for the single shunt current rebuild
// Assumes: short calibration of 4 samples
// Notes: expected currents queue up, a monitor pops them on each valid pulse
module single_shunt_phase_current_rebuild_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 4;
  logic core_clk = 1'b0;
  logic rst;
  logic period_start;
  logic motor_idle;
  wire logic leg_a_high_gate, leg_a_low_gate, leg_b_high_gate, leg_b_low_gate;
  wire logic leg_c_high_gate, leg_c_low_gate, shunt_sample_valid;
  wire logic [11:0] shunt_bus_current;
  logic signed [13:0] phase_a_current, phase_b_current, phase_c_current;
  logic [11:0] applied_offset;
  logic phase_currents_valid, offset_ok, offset_fault, gate_fault;
  wire logic [41:0] seen_cur = {phase_a_current, phase_b_current, phase_c_current};
  int mismatches = 0;
  int checks = 0;
  int seed = 84;
  int offs;
  logic cal_ok;
  logic [41:0] exp_q[$];
  logic [2:0] st[6] = '{3'h4, 3'h2, 3'h1, 3'h3, 3'h5, 3'h6};
  single_shunt_phase_current_rebuild #(.OFFSET_CHECK_SAMPLE_COUNT(N)) u_dut (.*);
  shunt_drive_model u_model (.*);
  always #4 core_clk = ~core_clk;
  task automatic check(input string what, input logic [41:0] seen, input logic [41:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    check("reset offset", 42'(applied_offset), 42'h800);
    check("reset flags", 42'({offset_ok, offset_fault, phase_currents_valid}), 42'h0);
  endtask
  task automatic calibrate(input int base, input int spread);
    int sum;
    int c;
    sum = 0;
    motor_idle = 1'b1;
    for (int i = 0; i < N; i++)
    begin
      if (i == 1)
      begin
        motor_idle = 1'b0;
        u_model.send(3'h0, 12'h000, 1);
        motor_idle = 1'b1;
      end
      c = base + $random(seed) % (spread + 1);
      sum += c;
      u_model.send(3'h0, 12'(c), 1);
    end
    @(negedge core_clk);
    motor_idle = 1'b0;
    offs = sum / N;
    cal_ok = (offs >= 1898 && offs <= 2198);
    check("offset ok", 42'(offset_ok), 42'(cal_ok));
    check("offset fault", 42'(offset_fault), 42'(!cal_ok));
    check("gate fault", 42'(gate_fault), 42'h0);
    if (cal_ok)
      check("applied offset", 42'(applied_offset), 42'(offs));
  endtask
  task automatic run_pair(input int i);
    int j;
    int c1;
    int c2;
    int cur[3];
    j = (i + 1) % 6;
    c1 = 2048 + $random(seed) % 1000;
    c2 = 2048 + $random(seed) % 1000;
    cur[i % 3] = (i < 3) ? c1 - offs : offs - c1;
    cur[j % 3] = (j < 3) ? c2 - offs : offs - c2;
    cur[3 - i % 3 - j % 3] = -(cur[i % 3] + cur[j % 3]);
    period_start = 1'b1;
    @(negedge core_clk);
    period_start = 1'b0;
    u_model.send(i[0] ? 3'h0 : 3'h7, 12'h123, 3);
    u_model.send(st[i], 12'(c1), 3 + i % 3);
    u_model.send(st[i], 12'(c1 + 7), 3);
    if (cal_ok)
      exp_q.push_back({14'(cur[0]), 14'(cur[1]), 14'(cur[2])});
    u_model.send(st[j], 12'(c2), 3);
    u_model.send(st[(i + 2) % 6], 12'h456, 3);
  endtask
  always @(negedge core_clk)
    if (phase_currents_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("spare valid", 42'h1, 42'h0);
      else
        check("currents", seen_cur, exp_q.pop_front());
    end
  initial
  begin
    period_start = 1'b0;
    motor_idle = 1'b0;
    do_reset();
    calibrate(2199, 0);
    run_pair(0);
    $display("test offset fault done");
    do_reset();
    calibrate(1898, 0);
    $display("test offset boundary done");
    do_reset();
    calibrate(2048, 150);
    for (int i = 0; i < 6; i++)
      run_pair(i);
    repeat (3) @(negedge core_clk);
    check("pending", 42'(exp_q.size()), 42'h0);
    $display("test rebuild done");
    give_verdict();
  end
  initial
  begin
    #(20000 * 8);
    mismatches++;
    give_verdict();
  end
endmodule
